// ### logic/ion_sweep_regs.vh
// Constants for the ion sweep count sequencer.
// Included by the sequencer design file; holds definitions only.
`ifndef ION_SWEEP_REGS_VH
`define ION_SWEEP_REGS_VH

// Clock and step timing
`define CLK_MHZ 250
`define STEP_TIME_US 100000
`define STEP_TIMER_W 25
`define HK_TIME_MS 1000
`define STEP_TIME_MS 100

// Sweep cycle layout, in steps
`define STEPS_PER_CYCLE 620
`define BKG_STEPS 15
`define CAL_STEPS 15
`define FLAG_ZERO_STEPS 30
`define STEP_IDX_W 10

// Source voltage setpoint, volts
`define HV_W 11
`define HV_START 11'h30C
`define HV_END 11'h7A8
`define HV_FINE_INC 11'h001
`define HV_COARSE_INC 11'h002
`define HV_FINE_STEPS 64

// Counting and compression
`define ACC_W 21
`define WORD_W 10
`define MANT_W 6
`define EXP_W 4

// Housekeeping multiplexer
`define HK_SEL_W 4
`define HK_POSITIONS 16

// Output buffer
`define FIFO_DEPTH 16
`define FIFO_AW 4

`endif

// ### logic/ion_sweep_count_sequencer.v
// Sweep sequencer, two-channel ion counters, compression and output buffer.
// Assumes detector pulses and switch inputs are synchronous to ref_clk;
// the telemetry side drains the buffer with a valid/ready handshake.
`timescale 1ns/1ps
`default_nettype none
`include "ion_sweep_regs.vh"

module sample_fifo #(
   parameter WIDTH = 21,
   parameter DEPTH = `FIFO_DEPTH,
   parameter AW = `FIFO_AW
) (
   // Clock and reset
   input wire ref_clk,
   input wire rstn,
   // Fill side
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   // Drain side
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr_q;
   reg [AW-1:0] rdPtr_q;
   reg [AW:0] count_q;
   wire push;
   wire pop;

   assign inReady = (count_q != DEPTH[AW:0]);
   assign outValid = (count_q != {(AW+1){1'b0}});
   assign outData = mem[rdPtr_q];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   always @(posedge ref_clk)
   begin
      if (push)
         mem[wrPtr_q] <= inData;
   end

   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wrPtr_q <= {AW{1'b0}};
         rdPtr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
         if (pop)
            rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
         if (push & ~pop)
            count_q <= count_q + 1'b1;
         else if (pop & ~push)
            count_q <= count_q - 1'b1;
      end
   end
endmodule // sample_fifo

// Behaviour
// - Step through 620 steps, 0.1 s each.
// - First 15 steps count background noise.
// - Next 15 steps are calibration.
// - Ramp setpoint 780 V to 1894 V, capped at 1960 V.
// - Two channels counted in parallel.
// - Each channel has 21-bit accumulator.
// - Compress to two 10-bit words plus flag.
// - Flag zero during first 30 steps.
// - Flag one for remaining 590 steps.
// - Cycle lasts 62 s, then repeats.
// - Housekeeping selector advances once per second.
// - Multiplier switch changes gain only.
// - Discriminator switch selects trigger threshold only.
// - Buffer updated only at internal step end.
module ion_sweep_count_sequencer #(
   parameter STEP_CYCLES = `STEP_TIME_US * `CLK_MHZ,
   parameter HK_STEPS = `HK_TIME_MS / `STEP_TIME_MS,
   parameter FINE_STEPS = `HV_FINE_STEPS,
   parameter DEPTH = `FIFO_DEPTH,
   parameter AW = `FIFO_AW
) (
   // Clock and reset
   input wire ref_clk,
   input wire rstn,
   // Discriminator outputs, high and low threshold, per channel
   input wire lowMassHiPulse,
   input wire lowMassLoPulse,
   input wire highMassHiPulse,
   input wire highMassLoPulse,
   // Operator switches
   input wire discHiSel,
   input wire mulHiSel,
   // Source and detector control
   output reg [`HV_W-1:0] hvSetpoint_q,
   output reg bkgActive_q,
   output reg calActive_q,
   output reg mulGainHi_q,
   output reg sweepFlag_q,
   output reg [`STEP_IDX_W-1:0] stepIdx_q,
   // Housekeeping multiplexer select
   output reg [`HK_SEL_W-1:0] hkSel_q,
   // Data sets to telemetry
   output wire setValid,
   input wire setReady,
   output wire [`WORD_W-1:0] lowMassWord,
   output wire [`WORD_W-1:0] highMassWord,
   output wire setFlag
);
   localparam integer STEP_LAST_N = STEP_CYCLES - 1;
   localparam integer LAST_STEP_N = `STEPS_PER_CYCLE - 1;
   localparam integer CAL_FIRST_N = `BKG_STEPS;
   localparam integer RAMP_FIRST_N = `FLAG_ZERO_STEPS;
   localparam integer FINE_LAST_N = `FLAG_ZERO_STEPS + FINE_STEPS;
   localparam integer HK_LAST_N = `HK_POSITIONS - 1;
   localparam integer HK_STEP_LAST_N = HK_STEPS - 1;
   localparam [`STEP_TIMER_W-1:0] STEP_LAST = STEP_LAST_N[`STEP_TIMER_W-1:0];
   localparam [`STEP_IDX_W-1:0] LAST_STEP = LAST_STEP_N[`STEP_IDX_W-1:0];
   localparam [`STEP_IDX_W-1:0] CAL_FIRST = CAL_FIRST_N[`STEP_IDX_W-1:0];
   localparam [`STEP_IDX_W-1:0] RAMP_FIRST = RAMP_FIRST_N[`STEP_IDX_W-1:0];
   localparam [`STEP_IDX_W-1:0] FINE_LAST = FINE_LAST_N[`STEP_IDX_W-1:0];
   localparam [`HK_SEL_W-1:0] HK_LAST = HK_LAST_N[`HK_SEL_W-1:0];
   localparam [`HK_SEL_W-1:0] HK_STEP_LAST = HK_STEP_LAST_N[`HK_SEL_W-1:0];
   localparam SET_W = 2 * `WORD_W + 1;

   reg [`STEP_TIMER_W-1:0] timer_q;
   reg [`STEP_TIMER_W-1:0] timer_d;
   reg [`STEP_IDX_W-1:0] stepIdx_d;
   reg [`HV_W-1:0] hvSetpoint_d;
   reg [`HK_SEL_W-1:0] hkDiv_q;
   reg [`ACC_W-1:0] lowAcc_q;
   reg [`ACC_W-1:0] highAcc_q;
   wire stepDone;
   wire advance;
   wire fifoInReady;
   wire lowPulse;
   wire highPulse;
   wire [SET_W-1:0] setIn;
   wire [SET_W-1:0] setOut;
   wire [`HV_W-1:0] hvInc;

   // Floating-point style count compression: exponent over mantissa
   function [`WORD_W-1:0] compress;
      input [`ACC_W-1:0] cnt;
      integer i;
      integer k;
      reg [`EXP_W-1:0] e;
      reg [`ACC_W-1:0] sh;
      begin
         e = {`EXP_W{1'b0}};
         for (i = `MANT_W; i < `ACC_W; i = i + 1)
         begin
            if (cnt[i])
            begin
               k = i - (`MANT_W - 1);
               e = k[`EXP_W-1:0];
            end
         end
         sh = cnt >> e;
         compress = {e, sh[`MANT_W-1:0]};
      end
   endfunction

   // Threshold choice ahead of the counters; gain switch only drives the multiplier
   assign lowPulse = discHiSel ? lowMassHiPulse : lowMassLoPulse;
   assign highPulse = discHiSel ? highMassHiPulse : highMassLoPulse;

   // Step end holds while the output buffer is full
   assign stepDone = (timer_q == STEP_LAST);
   assign advance = stepDone & fifoInReady;

   assign hvInc = (stepIdx_q < FINE_LAST) ? `HV_FINE_INC : `HV_COARSE_INC;

   always @*
   begin
      if (advance)
         timer_d = {`STEP_TIMER_W{1'b0}};
      else if (stepDone)
         timer_d = timer_q;
      else
         timer_d = timer_q + 1'b1;
   end

   always @*
   begin
      stepIdx_d = stepIdx_q;
      if (advance)
      begin
         if (stepIdx_q == LAST_STEP)
            stepIdx_d = {`STEP_IDX_W{1'b0}};
         else
            stepIdx_d = stepIdx_q + 1'b1;
      end
   end

   always @*
   begin
      hvSetpoint_d = hvSetpoint_q;
      if (advance)
      begin
         if (stepIdx_d <= RAMP_FIRST)
            hvSetpoint_d = `HV_START;
         else if (hvSetpoint_q + hvInc >= `HV_END)
            hvSetpoint_d = `HV_END;
         else
            hvSetpoint_d = hvSetpoint_q + hvInc;
      end
   end

   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         timer_q <= {`STEP_TIMER_W{1'b0}};
         stepIdx_q <= {`STEP_IDX_W{1'b0}};
         hvSetpoint_q <= `HV_START;
         bkgActive_q <= 1'b1;
         calActive_q <= 1'b0;
         sweepFlag_q <= 1'b0;
         mulGainHi_q <= 1'b0;
      end
      else
      begin
         timer_q <= timer_d;
         stepIdx_q <= stepIdx_d;
         hvSetpoint_q <= hvSetpoint_d;
         bkgActive_q <= (stepIdx_d < CAL_FIRST);
         calActive_q <= (stepIdx_d >= CAL_FIRST) && (stepIdx_d < RAMP_FIRST);
         sweepFlag_q <= (stepIdx_d >= RAMP_FIRST);
         mulGainHi_q <= mulHiSel;
      end
   end

   // Two independent accumulators, saturating, restarted at step end
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         lowAcc_q <= {`ACC_W{1'b0}};
         highAcc_q <= {`ACC_W{1'b0}};
      end
      else if (advance)
      begin
         lowAcc_q <= {{(`ACC_W-1){1'b0}}, lowPulse};
         highAcc_q <= {{(`ACC_W-1){1'b0}}, highPulse};
      end
      else
      begin
         if (lowPulse && (lowAcc_q != {`ACC_W{1'b1}}))
            lowAcc_q <= lowAcc_q + 1'b1;
         if (highPulse && (highAcc_q != {`ACC_W{1'b1}}))
            highAcc_q <= highAcc_q + 1'b1;
      end
   end

   // Housekeeping channel changes every HK_STEPS steps
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         hkDiv_q <= {`HK_SEL_W{1'b0}};
         hkSel_q <= {`HK_SEL_W{1'b0}};
      end
      else if (advance)
      begin
         if (hkDiv_q == HK_STEP_LAST)
         begin
            hkDiv_q <= {`HK_SEL_W{1'b0}};
            hkSel_q <= (hkSel_q == HK_LAST) ? {`HK_SEL_W{1'b0}} : hkSel_q + 1'b1;
         end
         else
            hkDiv_q <= hkDiv_q + 1'b1;
      end
   end

   // Finished step packed as flag, high-mass word, low-mass word
   assign setIn = {sweepFlag_q, compress(highAcc_q), compress(lowAcc_q)};

   sample_fifo #(
      .WIDTH(SET_W),
      .DEPTH(DEPTH),
      .AW(AW)
   ) setBuffer (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .inValid(stepDone),
      .inReady(fifoInReady),
      .inData(setIn),
      .outValid(setValid),
      .outReady(setReady),
      .outData(setOut)
   );

   assign lowMassWord = setOut[`WORD_W-1:0];
   assign highMassWord = setOut[2*`WORD_W-1:`WORD_W];
   assign setFlag = setOut[SET_W-1];
endmodule // ion_sweep_count_sequencer
`default_nettype wire

// ### sim/ion_sweep_properties.sv
// Port checker for the sweep sequencer.
// Assumes the single clock ref_clk and async active-low rstn.
`timescale 1ns/1ps
`default_nettype none
module ion_sweep_properties #(
   parameter STEP_CYCLES = 8
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic mulHiSel,
   input wire logic [10:0] hvSetpoint_q,
   input wire logic bkgActive_q,
   input wire logic calActive_q,
   input wire logic mulGainHi_q,
   input wire logic sweepFlag_q,
   input wire logic [9:0] stepIdx_q,
   input wire logic setValid,
   input wire logic setReady,
   input wire logic [9:0] lowMassWord,
   input wire logic [9:0] highMassWord,
   input wire logic setFlag
);
   logic [15:0] run_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // Cycles since the step index last moved
   always @(posedge ref_clk or negedge rstn)
      if (!rstn)
         run_q <= 16'h0000;
      else
         run_q <= $changed(stepIdx_q) ? 16'h0000 : run_q + 16'h0001;
   AST_STEP: assert property ($changed(stepIdx_q) |-> run_q >= STEP_CYCLES - 1) else $error("step short");
   AST_WRAP: assert property ($changed(stepIdx_q) |->
      stepIdx_q == (($past(stepIdx_q) == 10'h26B) ? 10'h000 : $past(stepIdx_q) + 10'h001)) else $error("bad step");
   AST_BKG: assert property (bkgActive_q == (stepIdx_q < 10'h00F)) else $error("bkg wrong");
   AST_CAL: assert property (calActive_q == (stepIdx_q >= 10'h00F && stepIdx_q < 10'h01E)) else $error("cal");
   AST_FLAG: assert property (sweepFlag_q == (stepIdx_q >= 10'h01E)) else $error("flag wrong");
   AST_HV_LOW: assert property (stepIdx_q <= 10'h01E |-> hvSetpoint_q == 11'h30C) else $error("hv low");
   AST_HV_MAX: assert property (hvSetpoint_q <= 11'h7A8) else $error("hv above top");
   AST_RAMP: assert property ($changed(stepIdx_q) && stepIdx_q > 10'h01E && stepIdx_q < 10'h05F
      |-> hvSetpoint_q == $past(hvSetpoint_q) + 11'h001) else $error("fine ramp");
   AST_GAIN: assert property (!$stable(mulHiSel) |=> mulGainHi_q == $past(mulHiSel)) else $error("gain");
   AST_HOLD: assert property (setValid && !setReady |=> setValid && $stable(lowMassWord)
      && $stable(highMassWord) && $stable(setFlag)) else $error("head moved");
   COV_WRAP: cover property ($changed(stepIdx_q) && stepIdx_q == 10'h000);
   COV_STALL: cover property ((setValid && !setReady) [*8]);
   COV_POP: cover property (setValid && setReady);
endmodule // ion_sweep_properties
bind ion_sweep_count_sequencer ion_sweep_properties #(.STEP_CYCLES(STEP_CYCLES)) props (.ref_clk, .rstn,
   .mulHiSel, .hvSetpoint_q, .bkgActive_q, .calActive_q, .mulGainHi_q, .sweepFlag_q, .stepIdx_q,
   .setValid, .setReady, .lowMassWord, .highMassWord, .setFlag);
`default_nettype wire

// ### sim/telemetry_sink.sv
// Telemetry sink draining the sequencer's output buffer.
// Assumes valid/ready on ref_clk; holdOff stalls it.
`timescale 1ns/1ps
`default_nettype none
module telemetry_sink (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Stall request
   input wire logic holdOff,
   // Data sets
   input wire logic setValid,
   input wire logic [9:0] lowMassWord,
   input wire logic [9:0] highMassWord,
   input wire logic setFlag,
   output logic setReady,
   output logic [10:0] rxCount
);
   logic [9:0] rxLow [0:1023];
   logic [9:0] rxHigh [0:1023];
   logic rxFlag [0:1023];
   always @(posedge ref_clk or negedge rstn)
      if (!rstn)
      begin
         setReady <= 1'b0;
         rxCount <= 11'h000;
      end
      else
      begin
         setReady <= !holdOff;
         // Sets kept strictly in arrival order
         if (setValid && setReady)
         begin
            rxLow[rxCount[9:0]] <= lowMassWord;
            rxHigh[rxCount[9:0]] <= highMassWord;
            rxFlag[rxCount[9:0]] <= setFlag;
            rxCount <= rxCount + 11'h001;
         end
      end
endmodule // telemetry_sink
`default_nettype wire

// ### sim/test_ion_sweep_count_sequencer.sv
// Bench for the sweep sequencer with a telemetry sink.
// Assumes 250 MHz ref_clk and steps shortened to STEP cycles.
`timescale 1ns/1ps
`default_nettype none
module test_ion_sweep_count_sequencer;
   localparam STEP = 100;
   logic ref_clk = 1'b0, rstn = 1'b0, discHiSel = 1'b1, mulHiSel = 1'b0, holdOff = 1'b0;
   logic lowHi = 1'b0, lowLo = 1'b0, highHi = 1'b0, highLo = 1'b0;
   wire [10:0] hv;
   wire bkg, cal, gain, flag, setValid, setReady, setFlag;
   wire [9:0] stepIdx, lowWord, highWord;
   wire [3:0] hkSel;
   integer miscompares = 0, tests_run = 0, cyc = 0, c1, i, r;
   logic [9:0] s;
   logic [43:0] rows [0:2];
   ion_sweep_count_sequencer #(.STEP_CYCLES(STEP), .HK_STEPS(2)) uut (.ref_clk, .rstn,
      .lowMassHiPulse(lowHi), .lowMassLoPulse(lowLo), .highMassHiPulse(highHi), .highMassLoPulse(highLo),
      .discHiSel, .mulHiSel, .hvSetpoint_q(hv), .bkgActive_q(bkg), .calActive_q(cal), .mulGainHi_q(gain),
      .sweepFlag_q(flag), .stepIdx_q(stepIdx), .hkSel_q(hkSel), .setValid, .setReady,
      .lowMassWord(lowWord), .highMassWord(highWord), .setFlag);
   telemetry_sink sink (.ref_clk, .rstn, .holdOff, .setValid, .lowMassWord(lowWord),
      .highMassWord(highWord), .setFlag, .setReady, .rxCount());
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp)
         begin
            miscompares = miscompares + 1;
            $display("BAD %0t got %0h want %0h", $time, got, exp);
         end
      end
   endtask
   task upto(input logic [9:0] n);
      while (stepIdx !== n)
         @(negedge ref_clk);
   endtask
   task print_verdict;
      begin
         if (miscompares == 0 && tests_run > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   initial
      forever #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 75000)
      begin
         miscompares = miscompares + 1;
         print_verdict;
      end
   end
   initial
   begin
      // Row: select, count a, count b, word of a, word of b
      rows[0] = 44'h10300003000;
      rows[1] = 44'h04005060005;
      rows[2] = 44'h15F3F06F03F;
      repeat (4) @(negedge ref_clk);
      rstn = 1'b1;
      chk(stepIdx, 10'h000);
      chk({flag, bkg, cal, setValid}, 4'h4);
      chk(hv, 11'h30C);
      for (r = 0; r < 3; r = r + 1)
      begin
         s = stepIdx;
         while (stepIdx === s)
            @(negedge ref_clk);
         if (r == 0)
            c1 = cyc;
         discHiSel = rows[r][40];
         repeat (2) @(negedge ref_clk);
         for (i = 0; i < 96; i = i + 1)
         begin
            lowHi = i < rows[r][39:32];
            highLo = lowHi;
            lowLo = i < rows[r][31:24];
            highHi = lowLo;
            @(negedge ref_clk);
         end
      end
      upto(10'h00F);
      chk({flag, bkg, cal}, 3'h1);
      upto(10'h01F);
      chk(hv, 11'h30D);
      chk({flag, bkg, cal}, 3'h4);
      for (r = 0; r < 3; r = r + 1)
      begin
         chk(sink.rxLow[r + 1], rows[r][40] ? rows[r][23:12] : rows[r][11:0]);
         chk(sink.rxHigh[r + 1], rows[r][40] ? rows[r][11:0] : rows[r][23:12]);
      end
      mulHiSel = 1'b1;
      upto(10'h028);
      chk(hkSel, 4'h4);
      chk(gain, 1'b1);
      upto(10'h05F);
      chk(hv, 11'h34E);
      upto(10'h26B);
      upto(10'h000);
      upto(10'h001);
      chk(cyc - c1, 620 * STEP);
      chk(sink.rxFlag[29], 1'b0);
      chk(sink.rxFlag[30], 1'b1);
      holdOff = 1'b1;
      s = stepIdx;
      repeat (25 * STEP) @(negedge ref_clk);
      chk(stepIdx, s + 10'h010);
      i = sink.rxCount;
      holdOff = 1'b0;
      repeat (40) @(negedge ref_clk);
      chk(sink.rxCount, i + 17);
      // Mid-run reset, then one full step from release
      rstn = 1'b0;
      @(negedge ref_clk);
      chk({stepIdx, hkSel, gain, setValid}, 16'h0000);
      chk({flag, bkg, cal, hv}, 14'h130C);
      rstn = 1'b1;
      c1 = cyc;
      upto(10'h001);
      chk(cyc - c1, STEP);
      print_verdict;
   end
endmodule // test_ion_sweep_count_sequencer
`default_nettype wire
